// ==== flag_branch_and_data_transfer_exec.sv ====
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`default_nettype none

module flag_branch_and_data_transfer_exec #(
	parameter int          PC_WIDTH = exec_pkg::DEF_PC_WIDTH,
	parameter logic [15:0] NVM_BASE = exec_pkg::DEF_NVM_BASE
) (
	// Clock and reset
	input  wire logic                  clock,
	input  wire logic                  srst,
	input  wire logic                  ce,
	// Instruction issue
	input  wire logic                  issueValid,
	input  wire exec_pkg::op_t         op,
	input  wire logic [4:0]            rd,
	input  wire logic [4:0]            rr,
	input  wire logic [7:0]            imm,
	input  wire logic [15:0]           directAddr,
	input  wire logic [6:0]            brOffset,
	input  wire exec_pkg::ptr_t        ptrSel,
	input  wire exec_pkg::mode_t       ptrMode,
	input  wire logic [5:0]            disp,
	input  wire logic [5:0]            ioSel,
	input  wire logic [7:0]            flags,
	output logic                       ready,
	output logic                       retire,
	output logic [PC_WIDTH-1:0]        pc,
	// Data space
	output logic [15:0]                memAddr,
	output logic [7:0]                 memWdata,
	output logic                       memWe,
	output logic                       memRe,
	input  wire logic [7:0]            memRdata,
	input  wire logic                  memWait,
	// Program memory
	output logic [15:0]                progAddr,
	output logic                       progRe,
	input  wire logic [15:0]           progRdata,
	// I/O space
	output logic [5:0]                 ioAddr,
	output logic [7:0]                 ioWdata,
	output logic                       ioWe,
	output logic                       ioRe,
	input  wire logic [7:0]            ioRdata,
	// Register port
	input  wire logic [5:0]            regAddr,
	input  wire logic [7:0]            regWdata,
	input  wire logic                  regWrite,
	input  wire logic                  regRead,
	output logic [7:0]                 regRdata
);
	import exec_pkg::*;

	if (PC_WIDTH < 9 || PC_WIDTH > 16) begin : g_pc_check
		$error("PC_WIDTH must lie between 9 and 16");
	end

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [7:0]          rf [32];
	logic [PC_WIDTH-1:0] pc_ff;
	logic [15:0]         sp_ff;
	state_t              state_ff;
	logic [1:0]          remCnt_ff;
	logic [4:0]          rdHold_ff;
	logic                loadPend_ff;
	logic                fromProg_ff;
	logic                zOdd_ff;
	logic                nvm_ff;
	logic [7:0]          regRdata_ff;

	logic                issue;
	logic                memOp;
	logic                isNvm;
	logic                isLoad;
	logic                finish;
	logic                hold;
	logic [2:0]          totalCyc;
	logic [4:0]          ptrLo;
	ptr_t                effSel;
	mode_t               effMode;
	logic [15:0]         ptrVal;
	logic [15:0]         ptrAddr;
	logic [15:0]         ptrNew;
	logic                ptrUpd;
	logic                brTaken;
	logic [PC_WIDTH-1:0] brTarget;
	logic [7:0]          loadByte;

	// ------------------------------------------------------------------
	// Address generation
	// ------------------------------------------------------------------
	always_comb begin
		effSel  = (op == OP_PROGRAM_MEMORY_FETCH) ? PTR_Z : ptrSel;
		effMode = (op inside {OP_OFFSET_FETCH, OP_OFFSET_WRITE}) ? MODE_DISP : ptrMode;
		ptrLo   = ptrLow(effSel);
		ptrVal  = {rf[5'(ptrLo + 5'h01)], rf[ptrLo]};
	end

	ptr_addr_unit u_ptr (
		.ptrVal (ptrVal),
		.mode   (effMode),
		.disp   (disp),
		.addr   (ptrAddr),
		.newPtr (ptrNew),
		.update (ptrUpd)
	);

	branch_cond_unit #(
		.PC_WIDTH (PC_WIDTH)
	) u_branch (
		.op     (op),
		.flags  (flags),
		.pc     (pc_ff),
		.offset (brOffset),
		.taken  (brTaken),
		.target (brTarget)
	);

	always_comb begin
		memOp = 1'b1;
		unique case (op)
			OP_DIRECT_FETCH, OP_DIRECT_WRITE:     memAddr = directAddr;
			OP_INDIRECT_FETCH, OP_OFFSET_FETCH,
			OP_INDIRECT_WRITE, OP_OFFSET_WRITE:   memAddr = ptrAddr;
			OP_STACK_PUSH:                        memAddr = sp_ff;
			OP_STACK_PULL:                        memAddr = 16'(sp_ff + 16'h0001);
			default: begin
				memAddr = 16'h0000;
				memOp   = 1'b0;
			end
		endcase
		isNvm    = memOp && (memAddr >= NVM_BASE);
		isLoad   = op inside {OP_DIRECT_FETCH, OP_INDIRECT_FETCH, OP_OFFSET_FETCH,
			OP_STACK_PULL, OP_PROGRAM_MEMORY_FETCH};
		totalCyc = 3'(cycleCount(op, brTaken) + (isNvm ? CYC_NVM_EXTRA : 3'h0));
	end

	// ------------------------------------------------------------------
	// Strobes toward memory and I/O
	// ------------------------------------------------------------------
	assign ready    = (state_ff == S_IDLE);
	assign issue    = ce && issueValid && ready;
	assign memWdata = rf[rr];
	assign memWe    = issue && (op inside {OP_DIRECT_WRITE, OP_INDIRECT_WRITE,
		OP_OFFSET_WRITE, OP_STACK_PUSH});
	assign memRe    = issue && (op inside {OP_DIRECT_FETCH, OP_INDIRECT_FETCH,
		OP_OFFSET_FETCH, OP_STACK_PULL});
	assign progAddr = ptrVal;
	assign progRe   = issue && (op == OP_PROGRAM_MEMORY_FETCH);
	assign ioAddr   = ioSel;
	assign ioWdata  = rf[rr];
	assign ioWe     = issue && (op == OP_IO_WRITE);
	assign ioRe     = issue && (op == OP_IO_READ);
	assign pc       = pc_ff;
	assign regRdata = regRdata_ff;

	// Extra wait cycles while the nonvolatile side is busy
	assign hold     = nvm_ff && memWait;
	assign finish   = ce && (state_ff == S_BUSY) && (remCnt_ff == 2'h0) && !hold;
	assign retire   = (issue && (totalCyc == CYC_ONE)) || finish;
	assign loadByte = fromProg_ff ? (zOdd_ff ? progRdata[15:8] : progRdata[7:0]) : memRdata;

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			state_ff  <= S_IDLE;
			remCnt_ff <= 2'h0;
		end else if (ce) begin
			if (issue && (totalCyc != CYC_ONE)) begin
				state_ff  <= S_BUSY;
				remCnt_ff <= 2'(totalCyc - 3'h2);
			end else if (state_ff == S_BUSY) begin
				if (remCnt_ff != 2'h0)
					remCnt_ff <= 2'(remCnt_ff - 2'h1);
				else if (!hold)
					state_ff <= S_IDLE;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			rdHold_ff   <= 5'h00;
			loadPend_ff <= 1'b0;
			fromProg_ff <= 1'b0;
			zOdd_ff     <= 1'b0;
			nvm_ff      <= 1'b0;
		end else if (issue) begin
			rdHold_ff   <= rd;
			loadPend_ff <= isLoad;
			fromProg_ff <= (op == OP_PROGRAM_MEMORY_FETCH);
			zOdd_ff     <= ptrVal[0];
			nvm_ff      <= isNvm;
		end
	end

	// ------------------------------------------------------------------
	// Program counter and stack pointer
	// ------------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst)
			pc_ff <= '0;
		else if (issue) begin
			if (isBranchOp(op) && brTaken)
				pc_ff <= brTarget;
			else if (op inside {OP_DIRECT_FETCH, OP_DIRECT_WRITE})
				pc_ff <= PC_WIDTH'(pc_ff + 2'h2);
			else
				pc_ff <= PC_WIDTH'(pc_ff + 1'b1);
		end else if (ce && regWrite && regAddr == OFF_PC_LO)
			pc_ff[7:0] <= regWdata;
		else if (ce && regWrite && regAddr == OFF_PC_HI)
			pc_ff[PC_WIDTH-1:8] <= regWdata[PC_WIDTH-9:0];
	end

	always_ff @(posedge clock) begin
		if (srst)
			sp_ff <= SP_RESET;
		else if (issue && op == OP_STACK_PUSH)
			sp_ff <= 16'(sp_ff - 16'h0001);
		else if (issue && op == OP_STACK_PULL)
			sp_ff <= 16'(sp_ff + 16'h0001);
		else if (ce && regWrite && regAddr == OFF_SP_LO)
			sp_ff[7:0] <= regWdata;
		else if (ce && regWrite && regAddr == OFF_SP_HI)
			sp_ff[15:8] <= regWdata;
	end

	// ------------------------------------------------------------------
	// Register file; core writes win over the register port
	// ------------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			for (int i = 0; i < 32; i++)
				rf[i] <= 8'h00;
		end else if (ce) begin
			if (regWrite && !regAddr[5])
				rf[regAddr[4:0]] <= regWdata;
			if (issue) begin
				unique case (op)
					OP_REGISTER_COPY:      rf[rd] <= rf[rr];
					OP_REGISTER_PAIR_COPY: begin
						rf[{rd[4:1], 1'b0}] <= rf[{rr[4:1], 1'b0}];
						rf[{rd[4:1], 1'b1}] <= rf[{rr[4:1], 1'b1}];
					end
					OP_IMMEDIATE_FETCH:    rf[rd] <= imm;
					OP_IO_READ:            rf[rd] <= ioRdata;
					default:               ;
				endcase
				if (ptrUpd && (op inside {OP_INDIRECT_FETCH, OP_INDIRECT_WRITE,
					OP_PROGRAM_MEMORY_FETCH})) begin
					rf[ptrLo]             <= ptrNew[7:0];
					rf[5'(ptrLo + 5'h01)] <= ptrNew[15:8];
				end
			end
			if (finish && loadPend_ff)
				rf[rdHold_ff] <= loadByte;
		end
	end

	always_ff @(posedge clock) begin
		if (srst)
			regRdata_ff <= 8'h00;
		else if (ce && regRead) begin
			if (!regAddr[5])
				regRdata_ff <= rf[regAddr[4:0]];
			else
				unique case (regAddr)
					OFF_SP_LO: regRdata_ff <= sp_ff[7:0];
					OFF_SP_HI: regRdata_ff <= sp_ff[15:8];
					OFF_PC_LO: regRdata_ff <= pc_ff[7:0];
					OFF_PC_HI: regRdata_ff <= 8'(16'(pc_ff) >> 8);
					default:   regRdata_ff <= 8'h00;
				endcase
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	branch_target_a: assert property (
		issue && isBranchOp(op) && brTaken |=>
		pc_ff == PC_WIDTH'($past(pc_ff) + {{(PC_WIDTH-7){$past(brOffset[6])}},
			$past(brOffset)} + 1'b1))
		else $error("taken branch target wrong");

	branch_timing_a: assert property (
		issue && isBranchOp(op) |-> if (brTaken) (!retire ##1 (state_ff == S_BUSY &&
			remCnt_ff == 2'h0)) else (retire ##1 state_ff == S_IDLE))
		else $error("branch cycle count wrong");

	direct_fetch_a: assert property (
		(issue && op == OP_DIRECT_FETCH && !isNvm) ##1 (ce && !retire) ##1 ce |-> retire)
		else $error("direct fetch not three cycles");

	offset_fetch_a: assert property (
		issue && op == OP_OFFSET_FETCH && !isNvm |-> memRe && !ptrUpd && !retire &&
		memAddr == 16'(ptrVal + {10'h000, disp}) ##1 (retire || !ce))
		else $error("offset fetch timing or address wrong");

	direct_write_a: assert property (
		issue && op == OP_DIRECT_WRITE && !isNvm |-> memWe && memAddr == directAddr &&
		!retire ##1 (state_ff == S_BUSY && remCnt_ff == 2'h0))
		else $error("direct write not two cycles");

	offset_write_a: assert property (
		issue && op == OP_OFFSET_WRITE && !isNvm |-> retire && memWe && !ptrUpd &&
		memAddr == 16'(ptrVal + {10'h000, disp}))
		else $error("offset write wrong");

	postinc_write_a: assert property (
		issue && op == OP_INDIRECT_WRITE && ptrMode == MODE_POST && !isNvm |->
		memAddr == ptrVal && retire ##1 ptrVal == 16'($past(ptrVal) + 16'h0001) ||
		$past(effSel) != effSel)
		else $error("post-increment write wrong");

	predec_write_a: assert property (
		issue && op == OP_INDIRECT_WRITE && ptrMode == MODE_PRE |->
		memAddr == 16'(ptrVal - 16'h0001) && memWe)
		else $error("pre-decrement write address wrong");

	stack_pull_a: assert property (
		(issue && op == OP_STACK_PULL && !isNvm) ##1 ce |-> retire && sp_ff ==
		16'($past(sp_ff) + 16'h0001))
		else $error("stack pull wrong");

	nvm_extra_a: assert property (
		issue && isNvm |-> !retire ##1 state_ff == S_BUSY)
		else $error("nonvolatile access lacks extra cycle");

	single_cycle_a: assert property (
		issue && (op inside {OP_REGISTER_COPY, OP_REGISTER_PAIR_COPY, OP_IMMEDIATE_FETCH,
			OP_IO_READ, OP_IO_WRITE} || (op == OP_STACK_PUSH && !isNvm)) |->
		retire ##1 ready)
		else $error("single-cycle operation stalled");

	prog_fetch_a: assert property (
		(issue && op == OP_PROGRAM_MEMORY_FETCH) ##1 ce ##1 ce |-> retire &&
		!$past(retire) && $past(progRe, 2))
		else $error("program fetch not three cycles");

endmodule // flag_branch_and_data_transfer_exec

`default_nettype wire

// ==== exec_pkg.sv ====
package exec_pkg;

	// ------------------------------------------------------------------
	// Operations issued by the decoder
	// ------------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_NOP                         = 5'h00,
		OP_JUMP_IF_HALF_CARRY_CLEAR    = 5'h01,
		OP_JUMP_IF_TRANSFER_FLAG_SET   = 5'h02,
		OP_JUMP_IF_TRANSFER_FLAG_CLEAR = 5'h03,
		OP_JUMP_IF_OVERFLOW_SET        = 5'h04,
		OP_JUMP_IF_OVERFLOW_CLEAR      = 5'h05,
		OP_JUMP_IF_INTERRUPTS_ENABLED  = 5'h06,
		OP_JUMP_IF_INTERRUPTS_DISABLED = 5'h07,
		OP_REGISTER_COPY               = 5'h08,
		OP_REGISTER_PAIR_COPY          = 5'h09,
		OP_IMMEDIATE_FETCH             = 5'h0A,
		OP_DIRECT_FETCH                = 5'h0B,
		OP_INDIRECT_FETCH              = 5'h0C,
		OP_OFFSET_FETCH                = 5'h0D,
		OP_DIRECT_WRITE                = 5'h0E,
		OP_INDIRECT_WRITE              = 5'h0F,
		OP_OFFSET_WRITE                = 5'h10,
		OP_PROGRAM_MEMORY_FETCH        = 5'h11,
		OP_IO_READ                     = 5'h12,
		OP_IO_WRITE                    = 5'h13,
		OP_STACK_PUSH                  = 5'h14,
		OP_STACK_PULL                  = 5'h15
	} op_t;

	typedef enum logic [1:0] {
		PTR_X = 2'h0,
		PTR_Y = 2'h1,
		PTR_Z = 2'h2
	} ptr_t;

	typedef enum logic [1:0] {
		MODE_PLAIN = 2'h0,
		MODE_POST  = 2'h1,
		MODE_PRE   = 2'h2,
		MODE_DISP  = 2'h3
	} mode_t;

	typedef enum logic [0:0] {
		S_IDLE = 1'h0,
		S_BUSY = 1'h1
	} state_t;

	// ------------------------------------------------------------------
	// Flag bit positions
	// ------------------------------------------------------------------
	localparam int FLAG_V = 3;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	// ------------------------------------------------------------------
	// Cycle counts
	// ------------------------------------------------------------------
	localparam logic [2:0] CYC_ONE          = 3'h1;
	localparam logic [2:0] CYC_BRANCH_TAKEN = 3'h2;
	localparam logic [2:0] CYC_DIRECT_FETCH = 3'h3;
	localparam logic [2:0] CYC_PTR_FETCH    = 3'h2;
	localparam logic [2:0] CYC_DIRECT_WRITE = 3'h2;
	localparam logic [2:0] CYC_PTR_WRITE    = 3'h1;
	localparam logic [2:0] CYC_STACK_PULL   = 3'h2;
	localparam logic [2:0] CYC_PROG_FETCH   = 3'h3;
	localparam logic [2:0] CYC_NVM_EXTRA    = 3'h1;

	// ------------------------------------------------------------------
	// Register port map and reset values
	// ------------------------------------------------------------------
	localparam logic [5:0]  OFF_SP_LO      = 6'h20;
	localparam logic [5:0]  OFF_SP_HI      = 6'h21;
	localparam logic [5:0]  OFF_PC_LO      = 6'h22;
	localparam logic [5:0]  OFF_PC_HI      = 6'h23;
	localparam logic [4:0]  PTR_BASE_IDX   = 5'h1A;
	localparam logic [15:0] SP_RESET       = 16'h0FFF;
	localparam int          DEF_PC_WIDTH   = 16;
	localparam logic [15:0] DEF_NVM_BASE   = 16'h8000;

	function automatic logic isBranchOp(input op_t op);
		return op inside {OP_JUMP_IF_HALF_CARRY_CLEAR, OP_JUMP_IF_TRANSFER_FLAG_SET,
			OP_JUMP_IF_TRANSFER_FLAG_CLEAR, OP_JUMP_IF_OVERFLOW_SET,
			OP_JUMP_IF_OVERFLOW_CLEAR, OP_JUMP_IF_INTERRUPTS_ENABLED,
			OP_JUMP_IF_INTERRUPTS_DISABLED};
	endfunction

	function automatic logic [2:0] cycleCount(input op_t op, input logic taken);
		unique case (op)
			OP_DIRECT_FETCH:                   return CYC_DIRECT_FETCH;
			OP_INDIRECT_FETCH, OP_OFFSET_FETCH: return CYC_PTR_FETCH;
			OP_DIRECT_WRITE:                   return CYC_DIRECT_WRITE;
			OP_INDIRECT_WRITE, OP_OFFSET_WRITE: return CYC_PTR_WRITE;
			OP_STACK_PULL:                     return CYC_STACK_PULL;
			OP_PROGRAM_MEMORY_FETCH:           return CYC_PROG_FETCH;
			default:                           return (isBranchOp(op) && taken) ?
				CYC_BRANCH_TAKEN : CYC_ONE;
		endcase
	endfunction

	function automatic logic [4:0] ptrLow(input ptr_t sel);
		return 5'(PTR_BASE_IDX + {2'h0, sel, 1'b0});
	endfunction

endpackage

// ==== ptr_addr_unit.sv ====
`timescale 1ns/1ns
`default_nettype none

module ptr_addr_unit (
	// Pointer and addressing mode
	input  wire logic            [15:0] ptrVal,
	input  wire exec_pkg::mode_t        mode,
	input  wire logic            [5:0]  disp,
	// Results
	output logic                 [15:0] addr,
	output logic                 [15:0] newPtr,
	output logic                        update
);
	import exec_pkg::*;

	always_comb begin
		unique case (mode)
			MODE_PRE:  addr = 16'(ptrVal - 16'h0001);
			MODE_DISP: addr = 16'(ptrVal + {10'h000, disp});
			default:   addr = ptrVal;
		endcase
		newPtr = (mode == MODE_POST) ? 16'(ptrVal + 16'h0001) : 16'(ptrVal - 16'h0001);
		update = (mode == MODE_POST) || (mode == MODE_PRE);
	end

endmodule // ptr_addr_unit

`default_nettype wire

// ==== branch_cond_unit.sv ====
`timescale 1ns/1ns
`default_nettype none

module branch_cond_unit #(
	parameter int PC_WIDTH = 16
) (
	// Branch request
	input  wire exec_pkg::op_t          op,
	input  wire logic [7:0]             flags,
	input  wire logic [PC_WIDTH-1:0]    pc,
	input  wire logic [6:0]             offset,
	// Decision
	output logic                        taken,
	output logic      [PC_WIDTH-1:0]    target
);
	import exec_pkg::*;

	always_comb begin
		unique case (op)
			OP_JUMP_IF_HALF_CARRY_CLEAR:    taken = !flags[FLAG_H];
			OP_JUMP_IF_TRANSFER_FLAG_SET:   taken = flags[FLAG_T];
			OP_JUMP_IF_TRANSFER_FLAG_CLEAR: taken = !flags[FLAG_T];
			OP_JUMP_IF_OVERFLOW_SET:        taken = flags[FLAG_V];
			OP_JUMP_IF_OVERFLOW_CLEAR:      taken = !flags[FLAG_V];
			OP_JUMP_IF_INTERRUPTS_ENABLED:  taken = flags[FLAG_I];
			OP_JUMP_IF_INTERRUPTS_DISABLED: taken = !flags[FLAG_I];
			default:                        taken = 1'b0;
		endcase
		// Signed offset plus one
		target = PC_WIDTH'(pc + {{(PC_WIDTH-7){offset[6]}}, offset} + 1'b1);
	end

endmodule // branch_cond_unit

`default_nettype wire

// ==== mem_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module mem_model #(
	parameter logic [15:0] NVM_BASE = 16'h8000
) (
	// Clock
	input  wire logic        clock,
	// Data space
	input  wire logic [15:0] memAddr,
	input  wire logic [7:0]  memWdata,
	input  wire logic        memWe,
	input  wire logic        memRe,
	output logic      [7:0]  memRdata,
	output logic             memWait,
	// Program memory
	input  wire logic [15:0] progAddr,
	input  wire logic        progRe,
	output logic      [15:0] progRdata,
	// I/O space
	input  wire logic [5:0]  ioAddr,
	input  wire logic [7:0]  ioWdata,
	input  wire logic        ioWe,
	input  wire logic        ioRe,
	output logic      [7:0]  ioRdata,
	// Bench control and log
	input  wire logic [2:0]  waitCycles,
	output logic      [15:0] lastWaddr,
	output logic      [7:0]  lastWdata,
	output logic      [13:0] lastIo
);
	logic [7:0]  memArr [256];
	logic [15:0] rdAddr_ff  = 16'h0000;
	logic [15:0] pgAddr_ff  = 16'h0000;
	logic [2:0]  waitCnt_ff = 3'h0;
	logic [15:0] rdAddr;
	logic [7:0]  pgWord;

	initial begin
		for (int i = 0; i < 256; i++) begin
			memArr[i] = 8'(i) ^ 8'h3C;
		end
	end

	// ------------------------------------------------------------------
	// Read paths: data and program words held after the strobe
	// ------------------------------------------------------------------
	assign rdAddr    = memRe ? memAddr : rdAddr_ff;
	assign memRdata  = memArr[rdAddr[7:0]];
	assign pgWord    = progRe ? progAddr[8:1] : pgAddr_ff[8:1];
	assign progRdata = {~pgWord, pgWord};
	// Outside its strobe the I/O bus shows a different pattern
	assign ioRdata   = ioRe ? {2'h2, ioAddr} : {2'h1, ~ioAddr};
	assign memWait   = (waitCnt_ff != 3'h0);

	// ------------------------------------------------------------------
	// Writes, log and slow answers
	// ------------------------------------------------------------------
	always @(posedge clock) begin
		if (memRe) begin
			rdAddr_ff <= memAddr;
		end
		if (progRe) begin
			pgAddr_ff <= progAddr;
		end
		if (memWe) begin
			memArr[memAddr[7:0]] <= memWdata;
			lastWaddr <= memAddr;
			lastWdata <= memWdata;
		end
		if (ioWe) begin
			lastIo <= {ioAddr, ioWdata};
		end
		// Nonvolatile targets only may stall
		if ((memRe || memWe) && memAddr >= NVM_BASE) begin
			waitCnt_ff <= waitCycles;
		end else if (waitCnt_ff != 3'h0) begin
			waitCnt_ff <= waitCnt_ff - 3'h1;
		end
	end
endmodule // mem_model

`default_nettype wire

// ==== flag_branch_and_data_transfer_exec_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none

module flag_branch_and_data_transfer_exec_tb_top;
	import exec_pkg::*;

	logic        clock, srst, ce, issueValid, ready, retire;
	op_t         op;
	logic [4:0]  rd, rr;
	logic [7:0]  imm, flags, k;
	logic [15:0] directAddr, pc, p0, memAddr, progAddr, progRdata, lastWaddr;
	wire  logic [6:0] brOffset;
	wire  logic [5:0] disp, ioSel;
	ptr_t        ptrSel;
	mode_t       ptrMode;
	logic [7:0]  memWdata, memRdata, ioWdata, ioRdata, regWdata, regRdata, lastWdata;
	logic        memWe, memRe, memWait, progRe, ioWe, ioRe, regWrite, regRead;
	logic [5:0]  ioAddr, regAddr;
	logic [2:0]  waitCycles;
	logic [13:0] lastIo;
	int          errCount = 0, totalChecks = 0, cycles = 0, n;
	op_t         bOp [7] = '{OP_JUMP_IF_HALF_CARRY_CLEAR, OP_JUMP_IF_TRANSFER_FLAG_SET,
		OP_JUMP_IF_TRANSFER_FLAG_CLEAR, OP_JUMP_IF_OVERFLOW_SET, OP_JUMP_IF_OVERFLOW_CLEAR,
		OP_JUMP_IF_INTERRUPTS_ENABLED, OP_JUMP_IF_INTERRUPTS_DISABLED};
	int          bBit [7] = '{5, 6, 6, 3, 3, 7, 7};
	logic        bPol [7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

	assign brOffset = imm[6:0];
	assign disp     = directAddr[5:0];
	assign ioSel    = directAddr[5:0];

	flag_branch_and_data_transfer_exec u_dut (
		.clock(clock), .srst(srst), .ce(ce), .issueValid(issueValid), .op(op),
		.rd(rd), .rr(rr), .imm(imm), .directAddr(directAddr), .brOffset(brOffset),
		.ptrSel(ptrSel), .ptrMode(ptrMode), .disp(disp), .ioSel(ioSel), .flags(flags),
		.ready(ready), .retire(retire), .pc(pc), .memAddr(memAddr), .memWdata(memWdata),
		.memWe(memWe), .memRe(memRe), .memRdata(memRdata), .memWait(memWait),
		.progAddr(progAddr), .progRe(progRe), .progRdata(progRdata), .ioAddr(ioAddr),
		.ioWdata(ioWdata), .ioWe(ioWe), .ioRe(ioRe), .ioRdata(ioRdata), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));

	mem_model #(.NVM_BASE(DEF_NVM_BASE)) u_mem (
		.clock(clock), .memAddr(memAddr), .memWdata(memWdata), .memWe(memWe), .memRe(memRe),
		.memRdata(memRdata), .memWait(memWait), .progAddr(progAddr), .progRe(progRe),
		.progRdata(progRdata), .ioAddr(ioAddr), .ioWdata(ioWdata), .ioWe(ioWe), .ioRe(ioRe),
		.ioRdata(ioRdata), .waitCycles(waitCycles), .lastWaddr(lastWaddr),
		.lastWdata(lastWdata), .lastIo(lastIo));

	// ------------------------------------------------------------------
	// Clock, timeout and checking tasks
	// ------------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errCount = errCount + 1;
			endSim();
		end
	end

	task automatic endSim();
		$display("checks %0d mismatches %0d", totalChecks, errCount);
		if (errCount == 0 && totalChecks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chkVal(input logic [15:0] got, input logic [15:0] exp);
		totalChecks++;
		if (got !== exp) begin
			errCount++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chkCyc(input int got, input int exp);
		totalChecks++;
		if (got != exp) begin
			errCount++;
			$display("BAD t=%0t cycles got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic regWr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr  <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask

	task automatic chkReg(input logic [5:0] a, input logic [7:0] e);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		@(posedge clock);
		chkVal({8'h00, regRdata}, {8'h00, e});
	endtask

	// Issue one operation and count cycles up to retire
	task automatic run(input op_t o, input logic [4:0] d, input logic [4:0] r,
		input logic [15:0] a, input logic [7:0] kk, input ptr_t ps, input mode_t pm);
		@(posedge clock);
		issueValid <= 1'b1;
		op         <= o;
		rd         <= d;
		rr         <= r;
		directAddr <= a;
		imm        <= kk;
		ptrSel     <= ps;
		ptrMode    <= pm;
		n = 0;
		do begin
			@(posedge clock);
			n++;
			issueValid <= 1'b0;
		end while (retire !== 1'b1 && n < 20);
		@(negedge clock);
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		{srst, issueValid, rd, rr, imm, directAddr} = '0;
		op = OP_NOP;
		ptrSel = PTR_X;
		ptrMode = MODE_PLAIN;
		ce = 1'b1;
		{flags, regAddr, regWdata, regWrite, regRead, waitCycles} = '0;
		srst = 1'b1;
		repeat (10) @(posedge clock);
		srst <= 1'b0;
		@(negedge clock);
		chkVal(pc, 16'h0000);
		chkReg(6'h20, 8'hFF);
		chkReg(6'h21, 8'h0F);
		regWr(6'h30, 8'h55);
		chkReg(6'h30, 8'h00);
		ce <= 1'b0;
		regWr(6'h07, 8'hEE);
		ce <= 1'b1;
		chkReg(6'h07, 8'h00);
		for (int i = 0; i < 7; i++) begin
			for (int t = 0; t < 2; t++) begin
				k = (i % 2 == 1) ? 8'h7C : 8'h09;
				@(posedge clock);
				flags <= ((t == 1) == bPol[i]) ? (8'h01 << bBit[i]) : ~(8'h01 << bBit[i]);
				@(negedge clock);
				p0 = pc;
				run(bOp[i], 5'h00, 5'h00, 16'h0000, k, PTR_X, MODE_PLAIN);
				@(negedge clock);
				chkCyc(n, t + 1);
				chkVal(pc, p0 + 16'h0001 + ((t == 1) ? {{9{k[6]}}, k[6:0]} : 16'h0000));
			end
		end
		run(OP_IMMEDIATE_FETCH, 5'h10, 5'h00, 16'h0000, 8'hA5, PTR_X, MODE_PLAIN);
		chkCyc(n, 1);
		run(OP_IMMEDIATE_FETCH, 5'h11, 5'h00, 16'h0000, 8'h3C, PTR_X, MODE_PLAIN);
		run(OP_REGISTER_PAIR_COPY, 5'h12, 5'h10, 16'h0000, 8'h00, PTR_X, MODE_PLAIN);
		chkCyc(n, 1);
		run(OP_REGISTER_COPY, 5'h14, 5'h10, 16'h0000, 8'h00, PTR_X, MODE_PLAIN);
		chkCyc(n, 1);
		chkReg(6'h12, 8'hA5);
		chkReg(6'h13, 8'h3C);
		chkReg(6'h14, 8'hA5);
		run(OP_IO_WRITE, 5'h00, 5'h11, 16'h0015, 8'h00, PTR_X, MODE_PLAIN);
		chkCyc(n, 1);
		chkVal({2'h0, lastIo}, 16'h153C);
		run(OP_IO_READ, 5'h15, 5'h00, 16'h000A, 8'h00, PTR_X, MODE_PLAIN);
		chkCyc(n, 1);
		chkReg(6'h15, 8'h8A);
		run(OP_STACK_PUSH, 5'h00, 5'h10, 16'h0000, 8'h00, PTR_X, MODE_PLAIN);
		chkCyc(n, 1);
		chkReg(6'h20, 8'hFE);
		run(OP_STACK_PULL, 5'h16, 5'h00, 16'h0000, 8'h00, PTR_X, MODE_PLAIN);
		chkCyc(n, 2);
		chkReg(6'h16, 8'hA5);
		chkReg(6'h20, 8'hFF);
		run(OP_DIRECT_WRITE, 5'h00, 5'h11, 16'h0100, 8'h00, PTR_X, MODE_PLAIN);
		chkCyc(n, 2);
		chkVal(lastWaddr, 16'h0100);
		chkVal({8'h00, lastWdata}, 16'h003C);
		run(OP_DIRECT_FETCH, 5'h17, 5'h00, 16'h0100, 8'h00, PTR_X, MODE_PLAIN);
		chkCyc(n, 3);
		chkReg(6'h17, 8'h3C);
		run(OP_DIRECT_FETCH, 5'h18, 5'h00, 16'h8004, 8'h00, PTR_X, MODE_PLAIN);
		chkCyc(n, 4);
		chkReg(6'h18, 8'h38);
		waitCycles <= 3'h5;
		run(OP_DIRECT_FETCH, 5'h19, 5'h00, 16'h8005, 8'h00, PTR_X, MODE_PLAIN);
		chkCyc(n, 7);
		chkReg(6'h19, 8'h39);
		waitCycles <= 3'h0;
		regWr(6'h1C, 8'h20);
		regWr(6'h1D, 8'h01);
		run(OP_OFFSET_WRITE, 5'h00, 5'h10, 16'h0005, 8'h00, PTR_Y, MODE_DISP);
		chkCyc(n, 1);
		chkVal(lastWaddr, 16'h0125);
		chkReg(6'h1C, 8'h20);
		run(OP_OFFSET_FETCH, 5'h02, 5'h00, 16'h0005, 8'h00, PTR_Y, MODE_DISP);
		chkCyc(n, 2);
		chkReg(6'h02, 8'hA5);
		regWr(6'h1A, 8'h30);
		regWr(6'h1B, 8'h01);
		run(OP_INDIRECT_WRITE, 5'h00, 5'h11, 16'h0000, 8'h00, PTR_X, MODE_POST);
		chkCyc(n, 1);
		chkVal(lastWaddr, 16'h0130);
		chkReg(6'h1A, 8'h31);
		run(OP_INDIRECT_FETCH, 5'h05, 5'h00, 16'h0000, 8'h00, PTR_X, MODE_PRE);
		chkCyc(n, 2);
		chkReg(6'h05, 8'h3C);
		chkReg(6'h1A, 8'h30);
		regWr(6'h1E, 8'h40);
		regWr(6'h1F, 8'h01);
		run(OP_INDIRECT_WRITE, 5'h00, 5'h10, 16'h0000, 8'h00, PTR_Z, MODE_PRE);
		chkCyc(n, 1);
		chkVal(lastWaddr, 16'h013F);
		chkReg(6'h1E, 8'h3F);
		run(OP_PROGRAM_MEMORY_FETCH, 5'h04, 5'h00, 16'h0000, 8'h00, PTR_Z, MODE_POST);
		chkCyc(n, 3);
		chkReg(6'h04, 8'h60);
		chkReg(6'h1E, 8'h40);
		endSim();
	end
endmodule // flag_branch_and_data_transfer_exec_tb_top

`default_nettype wire
